// ### lmm_exec.sv
`timescale 1ns/1ps
`default_nettype none
// Function
// - Bank load writes literal, flags untouched
// - Accumulator load writes literal, flags untouched
// - Multiply literal: accumulator times literal, unsigned
// - Product stored high byte, low byte
// - Multiply keeps accumulator, no flag, no zero
// - Multiply file: accumulator times file, unsigned
// - No overflow or carry from multiply
// - Access bit zero: access bank; one: bank select
module lmm_exec (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Instruction stream
    input wire logic instr_valid,
    input wire logic [15:0] instr_word,
    output logic instr_ready,
    // Data memory port
    output logic [lmm_pkg::ADDR_W-1:0] mem_addr,
    output logic mem_rd_en,
    input wire logic [7:0] mem_rd_data,
    output logic mem_wr_en,
    output logic [7:0] mem_wr_data,
    // Architectural state
    output logic [7:0] accumulator,
    output logic [7:0] bank_select_register,
    output logic [7:0] product_high_byte,
    output logic [7:0] product_low_byte,
    output logic product_done
);

    // Sequencer states
    typedef enum logic [0:0] {
        LMM_IDLE,       // Taking instructions
        LMM_FETCH       // Waiting for file operand
    } lmm_state_t;

    lmm_state_t state_r;            // Current state
    lmm_state_t state_nxt;          // Next state
    logic [7:0] acc_r;              // Working register
    logic [7:0] bank_r;             // Bank select
    logic [11:0] addr_r;            // Memory address
    logic rd_en_r;                  // Read strobe
    logic wr_en_r;                  // Write strobe
    logic [7:0] wr_data_r;          // Write data
    logic start_r;                  // Multiply launch
    logic [7:0] op_b_r;             // Multiply second operand
    logic take;                     // Instruction accepted
    logic [7:0] lit_k;              // Literal / file field
    logic is_load_bank;             // Decoded bank load
    logic is_load_acc;              // Decoded accumulator load
    logic is_mul_lit;               // Decoded multiply literal
    logic is_mul_file;              // Decoded multiply file
    logic is_store_acc;             // Decoded store
    logic [11:0] file_addr;         // Resolved file address

    lmm_mul_if mul_link ();

    // =================================================================
    // Decode helpers
    // =================================================================
    // bank choice
    // Access bit low ignores the bank select entirely
    function automatic logic [11:0] resolve_addr(input logic access,
                                                 input logic [7:0] f,
                                                 input logic [7:0] bank);
        logic [3:0] b;
        b = bank[3:0];
        if (!access) begin
            b = (f < lmm_pkg::ACCESS_SPLIT) ? lmm_pkg::ACCESS_LOW_BANK
                                            : lmm_pkg::ACCESS_HIGH_BANK;
        end
        resolve_addr = {b, f};
    endfunction : resolve_addr

    assign lit_k = instr_word[lmm_pkg::LIT_LSB +: 8];
    assign take = instr_valid && instr_ready;
    // Operand fetch occupies one extra cycle, so stall the stream then
    assign instr_ready = (state_r == LMM_IDLE);
    assign is_load_bank = (instr_word[15:8] == lmm_pkg::OPC_LOAD_BANK);
    assign is_load_acc = (instr_word[15:8] == lmm_pkg::OPC_LOAD_ACC);
    assign is_mul_lit = (instr_word[15:8] == lmm_pkg::OPC_MUL_LIT);
    assign is_mul_file = (instr_word[15:9] == lmm_pkg::OPC_MUL_FILE);
    assign is_store_acc = (instr_word[15:9] == lmm_pkg::OPC_STORE_ACC);
    assign file_addr = resolve_addr(instr_word[lmm_pkg::ACCESS_BIT], lit_k, bank_r);

    // =================================================================
    // Sequencer
    // =================================================================
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            // File multiply waits one cycle for the operand
            LMM_IDLE: begin
                if (take && is_mul_file) begin
                    state_nxt = LMM_FETCH;
                end
            end
            LMM_FETCH: begin
                state_nxt = LMM_IDLE;
            end
            default: begin
                state_nxt = LMM_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= LMM_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // =================================================================
    // Architectural registers
    // =================================================================
    // bank literal load
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            bank_r <= lmm_pkg::BANK_RST;
        end else if (take && is_load_bank) begin
            bank_r <= lit_k;
        end
    end

    // multiply leaves accumulator
    // Only the literal load writes here; multiplies never do
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            acc_r <= lmm_pkg::ACC_RST;
        end else if (take && is_load_acc) begin
            acc_r <= lit_k;
        end
    end

    // =================================================================
    // Data memory port
    // =================================================================
    // store accumulator to file
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            addr_r <= 12'h000;
            rd_en_r <= 1'b0;
            wr_en_r <= 1'b0;
            wr_data_r <= 8'h00;
        end else begin
            rd_en_r <= take && is_mul_file;
            wr_en_r <= take && is_store_acc;
            // Address held until the next file access
            if (take && (is_mul_file || is_store_acc)) begin
                addr_r <= file_addr;
            end
            if (take && is_store_acc) begin
                wr_data_r <= acc_r;
            end
        end
    end

    // =================================================================
    // Multiply launch
    // =================================================================
    // literal multiply launch
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            start_r <= 1'b0;
            op_b_r <= 8'h00;
        end else begin
            start_r <= (take && is_mul_lit) || (state_r == LMM_FETCH);
            if (take && is_mul_lit) begin
                op_b_r <= lit_k;
            end else if (state_r == LMM_FETCH) begin
                op_b_r <= mem_rd_data;
            end
        end
    end

    assign mul_link.start = start_r;
    assign mul_link.op_b = op_b_r;
    // Accumulator cannot change between launch and use; a load taken while start is high lands on the same edge as the product
    assign mul_link.op_a = acc_r;

    lmm_mult u_mult (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .mul(mul_link.unit)
    );

    // =================================================================
    // Outputs
    // =================================================================
    assign mem_addr = addr_r;
    assign mem_rd_en = rd_en_r;
    assign mem_wr_en = wr_en_r;
    assign mem_wr_data = wr_data_r;
    assign accumulator = acc_r;
    assign bank_select_register = bank_r;
    assign product_high_byte = mul_link.product[15:8];
    assign product_low_byte = mul_link.product[7:0];
    assign product_done = mul_link.done;

    // =================================================================
    // Checks
    // =================================================================
    bank_load_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        take && is_load_bank |=> bank_r == $past(lit_k))
        else $error("bank select not loaded from literal");

    acc_load_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        take && is_load_acc |=> acc_r == $past(lit_k))
        else $error("accumulator not loaded from literal");

    mul_lit_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        take && is_mul_lit |-> ##2 product_done &&
            {product_high_byte, product_low_byte} ==
            16'($past(acc_r, 2)) * 16'($past(lit_k, 2)))
        else $error("literal multiply gave the wrong product");

    mul_keeps_acc_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        take && (is_mul_lit || is_mul_file) |=> $stable(acc_r))
        else $error("multiply altered the accumulator");

    mul_file_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        state_r == LMM_FETCH |-> ##2 product_done &&
            {product_high_byte, product_low_byte} ==
            16'($past(acc_r, 2)) * 16'($past(mem_rd_data, 2)))
        else $error("file multiply gave the wrong product");

    access_bank_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        take && is_store_acc && !instr_word[lmm_pkg::ACCESS_BIT] |=>
            mem_addr[11:8] == ($past(lit_k) < lmm_pkg::ACCESS_SPLIT ?
            lmm_pkg::ACCESS_LOW_BANK : lmm_pkg::ACCESS_HIGH_BANK))
        else $error("access bank not selected");

    banked_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        take && is_mul_file && instr_word[lmm_pkg::ACCESS_BIT] |=>
            mem_rd_en && mem_addr == {$past(bank_r[3:0]), $past(lit_k)})
        else $error("bank select not used for banked access");

    store_acc_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        take && is_store_acc |=> mem_wr_en && mem_wr_data == $past(acc_r)
            ##1 !mem_wr_en || $past(take && is_store_acc))
        else $error("store did not write the accumulator");

endmodule : lmm_exec
`default_nettype wire

// ### lmm_pkg.sv
// =====================================================================
// Shared constants for the literal / move / multiply execution block
// =====================================================================
`default_nettype none
package lmm_pkg;

    // =================================================================
    // Widths
    // =================================================================
    localparam int DATA_W = 8;      // Accumulator and file register width
    localparam int PROD_W = 16;     // Full unsigned product width
    localparam int ADDR_W = 12;     // Flat data space address width
    localparam int BANK_W = 4;      // Bank bits used from the bank select

    // =================================================================
    // Opcode fields, compared against the top bits of the word
    // =================================================================
    localparam logic [7:0] OPC_LOAD_BANK = 8'h01;   // Bits 15:8
    localparam logic [7:0] OPC_LOAD_ACC = 8'h0E;    // Bits 15:8
    localparam logic [7:0] OPC_MUL_LIT = 8'h0D;     // Bits 15:8
    localparam logic [6:0] OPC_MUL_FILE = 7'h01;    // Bits 15:9
    localparam logic [6:0] OPC_STORE_ACC = 7'h37;   // Bits 15:9

    // =================================================================
    // Field positions in the instruction word
    // =================================================================
    localparam int ACCESS_BIT = 8;  // Bank choice bit of file instructions
    localparam int LIT_LSB = 0;     // Literal / file address low bit

    // =================================================================
    // Access bank mapping
    // =================================================================
    localparam logic [7:0] ACCESS_SPLIT = 8'h80;    // Low half / high half
    localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;  // Bank for low half
    localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF; // Bank for high half

    // =================================================================
    // Reset values
    // =================================================================
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic [7:0] BANK_RST = 8'h00;
    localparam logic [15:0] PROD_RST = 16'h0000;
    localparam logic [15:0] PROD_MAX = 16'hFE01;    // 255 x 255

endpackage : lmm_pkg
`default_nettype wire

// ### lmm_mul_if.sv
`timescale 1ns/1ps
`default_nettype none
// =====================================================================
// Link between the decoder and the multiply unit
// =====================================================================
interface lmm_mul_if;
    logic start;            // One-cycle launch pulse
    logic [7:0] op_a;       // Accumulator operand
    logic [7:0] op_b;       // Literal or file operand
    logic done;             // One-cycle result pulse
    logic [15:0] product;   // Held product pair

    // Decoder side
    modport requester (output start, output op_a, output op_b,
                       input done, input product);
    // Multiply unit side
    modport unit (input start, input op_a, input op_b,
                  output done, output product);
endinterface : lmm_mul_if
`default_nettype wire

// ### lmm_mult.sv
`timescale 1ns/1ps
`default_nettype none
// =====================================================================
// Unsigned 8x8 multiplier holding the product register pair
// =====================================================================
module lmm_mult (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Decoder link
    lmm_mul_if.unit mul
);

    // Product pair, high byte on top
    logic [15:0] prod_r;
    // Result strobe
    logic done_r;

    // =================================================================
    // Product pair update
    // =================================================================
    // product pair split
    // Whole product lands at once, so no half-written pair is visible
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            prod_r <= lmm_pkg::PROD_RST;
        end else if (mul.start) begin
            // no carry, no overflow
            // Full width kept; no carry or overflow exists
            prod_r <= 16'(mul.op_a) * 16'(mul.op_b);
        end
    end

    // Result strobe one cycle after launch
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            done_r <= 1'b0;
        end else begin
            done_r <= mul.start;
        end
    end

    assign mul.product = prod_r;
    assign mul.done = done_r;

    // =================================================================
    // Checks
    // =================================================================
    prod_split_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        mul.done |-> prod_r == 16'($past(mul.op_a)) * 16'($past(mul.op_b)))
        else $error("product pair does not hold the launched product");

    prod_range_a: assert property (
        @(posedge clk_sys) disable iff (!rst_n)
        prod_r <= lmm_pkg::PROD_MAX)
        else $error("product exceeds the largest 8x8 result");

endmodule : lmm_mult
`default_nettype wire

// ### tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin \
    $display("mismatch %s expected %h seen %h", nm, e, g); failures++; end end

module tb_top;
    // =================================================================
    // Signals
    // =================================================================
    logic clk_sys;
    logic rst_n;
    logic instr_valid;
    logic [15:0] instr_word;
    logic instr_ready;
    logic [lmm_pkg::ADDR_W-1:0] mem_addr;
    logic mem_rd_en;
    logic [7:0] mem_rd_data;
    logic mem_wr_en;
    logic [7:0] mem_wr_data;
    logic [7:0] accumulator;
    logic [7:0] bank_select_register;
    logic [7:0] product_high_byte;
    logic [7:0] product_low_byte;
    logic product_done;
    int failures = 0;        // Mismatch count
    int num_checks = 0;      // Comparison count
    int seed = 91;           // Fixed seed keeps runs repeatable
    logic [7:0] acc_m;       // Expected accumulator
    logic [7:0] bank_m;      // Expected bank select
    logic [15:0] prod_m;     // Expected product pair
    logic [7:0] junk_r = 8'hA5; // Pattern on the idle read bus

    // =================================================================
    // Design under test
    // =================================================================
    lmm_exec u_dut (
        .clk_sys(clk_sys), .rst_n(rst_n),
        .instr_valid(instr_valid), .instr_word(instr_word), .instr_ready(instr_ready),
        .mem_addr(mem_addr), .mem_rd_en(mem_rd_en), .mem_rd_data(mem_rd_data),
        .mem_wr_en(mem_wr_en), .mem_wr_data(mem_wr_data),
        .accumulator(accumulator), .bank_select_register(bank_select_register),
        .product_high_byte(product_high_byte), .product_low_byte(product_low_byte),
        .product_done(product_done)
    );

    // =================================================================
    // Expectation helpers
    // =================================================================
    // Flat address from access bit, file field and bank select
    function automatic logic [11:0] addr_of(input logic [15:0] w, input logic [7:0] bank);
        if (w[8]) return {bank[3:0], w[7:0]};
        return w[7] ? {4'hF, w[7:0]} : {4'h0, w[7:0]};
    endfunction : addr_of

    // Memory contents as a fixed function of the address
    function automatic logic [7:0] mdat(input logic [11:0] a);
        return a[7:0] ^ {a[11:8], a[11:8]} ^ 8'h5A;
    endfunction : mdat

    // Clock, 10 ns period
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // Idle read bus changes every cycle so stale data matches only while junk_r is FF
    always @(negedge clk_sys) junk_r <= junk_r + 8'h3B;
    always_comb mem_rd_data = mem_rd_en ? mdat(mem_addr) : ~mdat(mem_addr) ^ junk_r;

    // =================================================================
    // Tasks
    // =================================================================
    task automatic finish_test();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : finish_test

    // Present a word at a falling edge; ends one falling edge after the take
    task automatic issue(input logic [15:0] w);
        int k;
        k = 0;
        instr_valid = 1'b1;
        instr_word = w;
        while (instr_ready !== 1'b1 && k < 20) begin
            @(negedge clk_sys);
            k++;
        end
        if (k == 20) begin
            failures++;
            finish_test();
        end
        @(posedge clk_sys);
        @(negedge clk_sys);
    endtask : issue

    // One instruction alone, checked cycle by cycle
    task automatic run(input logic [15:0] w);
        logic [11:0] a;
        a = addr_of(w, bank_m);
        issue(w);
        instr_valid = 1'b0;
        if (w[15:8] == 8'h01) begin
            bank_m = w[7:0];
            `CHK("bank", bank_m, bank_select_register)
        end else if (w[15:8] == 8'h0E) begin
            acc_m = w[7:0];
            `CHK("acc", acc_m, accumulator)
        end else if (w[15:8] == 8'h0D) begin
            `CHK("early done", 1'b0, product_done)
            @(negedge clk_sys);
            prod_m = {8'h00, acc_m} * {8'h00, w[7:0]};
            `CHK("done lit", 1'b1, product_done)
            `CHK("hi lit", prod_m[15:8], product_high_byte)
            `CHK("lo lit", prod_m[7:0], product_low_byte)
        end else if (w[15:9] == 7'h01) begin
            `CHK("rd en", 1'b1, mem_rd_en)
            `CHK("rd addr", a, mem_addr)
            `CHK("ready", 1'b0, instr_ready)
            repeat (2) @(negedge clk_sys);
            prod_m = {8'h00, acc_m} * {8'h00, mdat(a)};
            `CHK("done file", 1'b1, product_done)
            `CHK("prod file", prod_m, {product_high_byte, product_low_byte})
        end else if (w[15:9] == 7'h37) begin
            `CHK("wr en", 1'b1, mem_wr_en)
            `CHK("wr addr", a, mem_addr)
            `CHK("wr data", acc_m, mem_wr_data)
        end else begin
            `CHK("nop wr", 1'b0, mem_wr_en)
            `CHK("nop rd", 1'b0, mem_rd_en)
        end
        `CHK("acc kept", acc_m, accumulator)
        `CHK("bank kept", bank_m, bank_select_register)
        `CHK("prod kept", prod_m, {product_high_byte, product_low_byte})
    endtask : run

    // =================================================================
    // Main sequence
    // =================================================================
    initial begin
        logic [15:0] base [6];
        logic [15:0] r;
        int idx;
        base = '{16'h0100, 16'h0E00, 16'h0D00, 16'h0200, 16'h6E00, 16'h0000};
        rst_n = 1'b0;
        instr_valid = 1'b0;
        instr_word = 16'h0000;
        acc_m = 8'h00;
        bank_m = 8'h00;
        prod_m = 16'h0000;
        repeat (5) @(posedge clk_sys);
        @(negedge clk_sys);
        `CHK("rst ready", 1'b1, instr_ready)
        `CHK("rst prod", 16'h0000, {product_high_byte, product_low_byte})
        rst_n = 1'b1;
        // Corner cases: largest product, zero product, every bank path
        run(16'h0EFF);
        run(16'h0DFF);
        run(16'h0D00);
        run(16'h0105);
        run(16'h0320);
        run(16'h0290);
        run(16'h0210);
        run(16'h6E85);
        run(16'h6F33);
        run(16'h0000);
        // Multiply then reload: product uses the old accumulator
        run(16'h0E37);
        issue(16'h0D11);
        issue(16'h0E99);
        instr_valid = 1'b0;
        prod_m = 16'h03A7;
        acc_m = 8'h99;
        `CHK("b2b done", 1'b1, product_done)
        `CHK("b2b prod", prod_m, {product_high_byte, product_low_byte})
        `CHK("b2b acc", acc_m, accumulator)
        // File multiply holds off the next word for one cycle
        run(16'h0E0C);
        issue(16'h0240);
        issue(16'h0E01);
        instr_valid = 1'b0;
        prod_m = 16'h0138;
        acc_m = 8'h01;
        `CHK("hold done", 1'b1, product_done)
        `CHK("hold prod", prod_m, {product_high_byte, product_low_byte})
        // Random mix of every opcode
        repeat (300) begin
            r = 16'($random(seed));
            idx = ($random(seed) & 32'h7FFF_FFFF) % 6;
            if (idx == 5) r = 16'h0000;
            else if (idx < 3) r = {8'h00, r[7:0]};
            else r = {7'h00, r[8:0]};
            run(base[idx] | r);
        end
        finish_test();
    end
endmodule : tb_top
`default_nettype wire
